// [verilog/sfep_pkg.sv]
// constants shared by the serial flash erase and program sequencer
package sfep_pkg;

  // core clock rate, used to turn times into cycle counts
  localparam int unsigned CLK_MHZ = 250;

  // opcodes; values are fixed localparams
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OP_FOUR_KIB_WIPE = 8'h20;
  localparam logic [7:0] OP_BLOCK32_WIPE = 8'h52;
  localparam logic [7:0] OP_BLOCK64_WIPE = 8'hd8;
  localparam logic [7:0] OP_CHIP_WIPE = 8'h60;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_WRITE = 8'h38;

  // register offsets on the plain register port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_LOCK_IDX = 4'h8;
  localparam logic [3:0] REG_LOCK_DATA = 4'hc;

  // field positions
  localparam int unsigned CTRL_PSS_BIT = 0;
  localparam int unsigned CTRL_QE_BIT = 1;
  localparam int unsigned CTRL_QPI_BIT = 2;
  localparam int unsigned CTRL_BP_LSB = 3;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_LATCH_BIT = 1;
  localparam int unsigned STAT_REJECT_BIT = 2;
  localparam int unsigned LOCK_PERSIST_BIT = 0;
  localparam int unsigned LOCK_DYNAMIC_BIT = 1;

  // reset values
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam logic [31:0] TIMER_RESET = 32'h0000_0000;

  // erase extent codes on the array port
  localparam logic [1:0] LEN_4K = 2'h0;
  localparam logic [1:0] LEN_32K = 2'h1;
  localparam logic [1:0] LEN_64K = 2'h2;

  // array geometry in 4K sectors
  localparam int unsigned SECTORS = 512;
  localparam logic [4:0] SEC_PER_4K = 5'd1;
  localparam logic [4:0] SEC_PER_32K = 5'd8;
  localparam logic [4:0] SEC_PER_64K = 5'd16;

  // page write time is short enough to stay fixed here
  localparam int unsigned PAGE_WRITE_TIME_NS = 1000;
  localparam int unsigned PAGE_WRITE_CYC = (PAGE_WRITE_TIME_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WALK = 5'b00010,
    ST_PREAD = 5'b00100,
    ST_PWRITE = 5'b01000,
    ST_WAIT = 5'b10000
  } sfep_state_t;

endpackage

// [verilog/sfep_sequencer.sv]
// erase and page write command sequencer of a serial nor flash
`timescale 1ns/1ps
module sfep_sequencer #(
  parameter int unsigned SECTOR_WIPE_TIME_US = 30,
  parameter int unsigned BLOCK32_WIPE_TIME_US = 150,
  parameter int unsigned BLOCK64_WIPE_TIME_US = 300,
  parameter int unsigned CHIP_WIPE_TIME_US = 10000
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic chip_select_n,
  input wire logic serial_clk,
  input wire logic [3:0] quad_io_lines,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  output logic busy_flag,
  output logic write_unlock_latch,
  output logic mem_erase,
  output logic [1:0] mem_erase_len,
  output logic [20:0] mem_erase_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [20:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);

  localparam logic [31:0] SECTOR_WIPE_CYC = 32'(SECTOR_WIPE_TIME_US * sfep_pkg::CLK_MHZ);
  localparam logic [31:0] BLOCK32_WIPE_CYC = 32'(BLOCK32_WIPE_TIME_US * sfep_pkg::CLK_MHZ);
  localparam logic [31:0] BLOCK64_WIPE_CYC = 32'(BLOCK64_WIPE_TIME_US * sfep_pkg::CLK_MHZ);
  localparam logic [31:0] CHIP_WIPE_CYC = 32'(CHIP_WIPE_TIME_US * sfep_pkg::CLK_MHZ);
  localparam logic [31:0] PAGE_WRITE_CYC = 32'(sfep_pkg::PAGE_WRITE_CYC);

  typedef struct packed {
    logic cs_m;
    logic cs_s;
    logic cs_p;
    logic sck_m;
    logic sck_s;
    logic sck_p;
    logic [3:0] io_m;
    logic [3:0] io_s;
    logic pss;
    logic qe;
    logic quad_command_mode;
    logic [3:0] bp;
    logic [8:0] lock_idx;
    logic [511:0] plock;
    logic [511:0] dlock;
    logic latch;
    logic busy;
    logic reject;
    logic [31:0] rdata;
    logic [7:0] op;
    logic [7:0] sh;
    logic [3:0] bitcnt;
    logic [2:0] bytecnt;
    logic [23:0] addr;
    logic [7:0] pofs;
    logic [255:0][7:0] pbuf;
    logic [255:0] pval;
    sfep_pkg::sfep_state_t st;
    logic [31:0] timer;
    logic [8:0] idx;
    logic mem_erase;
    logic [1:0] mem_len;
    logic [20:0] mem_eaddr;
    logic mem_rd;
    logic mem_wr;
    logic [20:0] mem_addr;
    logic [7:0] mem_wdata;
  } sfep_regs_t;

  sfep_regs_t q;
  sfep_regs_t d;

  // bp decode: top 2^(bp-1) 64K blocks, everything from six up
  function automatic logic sfep_bp_prot(input logic [4:0] blk, input logic [3:0] bp);
    if (bp == 4'h0) begin
      return 1'b0;
    end
    if (bp > 4'h5) begin
      return 1'b1;
    end
    return {1'b0, blk} >= (6'd32 - (6'd1 << (bp - 4'h1)));
  endfunction

  // any protected sector in [lo, lo+n) under the active scheme
  function automatic logic sfep_prot(input logic [8:0] lo, input logic [4:0] n,
                                     input logic pss, input logic [3:0] bp,
                                     input logic [511:0] lk);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < sfep_pkg::SECTORS; i++) begin
      if (i >= int'(lo) && i < int'(lo) + int'(n)) begin
        if (pss) begin
          hit = hit | lk[i];
        end else begin
          hit = hit | sfep_bp_prot(5'(i >> 4), bp);
        end
      end
    end
    return hit;
  endfunction

  logic sck_rise;
  logic cs_rise;
  logic cs_fall;
  logic quad;
  logic [7:0] nsh;
  logic [3:0] nbit;
  logic bnd;
  logic [8:0] cmd_lo;
  logic [4:0] cmd_n;
  logic cmd_prot;
  logic walk_prot;

  always_comb begin
    d = q;
    sck_rise = q.sck_s & ~q.sck_p;
    cs_rise = q.cs_s & ~q.cs_p;
    cs_fall = ~q.cs_s & q.cs_p;
    // quad page write switches to four lanes after its opcode
    quad = q.quad_command_mode | (q.op == sfep_pkg::OP_QUAD_PAGE_WRITE && q.bytecnt != 3'd0);
    nsh = quad ? {q.sh[3:0], q.io_s} : {q.sh[6:0], q.io_s[0]};
    nbit = q.bitcnt + (quad ? 4'd4 : 4'd1);
    bnd = q.bitcnt == 4'd0;
    cmd_lo = q.addr[20:12];
    cmd_n = sfep_pkg::SEC_PER_4K;
    if (q.op == sfep_pkg::OP_BLOCK32_WIPE) begin
      cmd_lo = {q.addr[20:15], 3'b000};
      cmd_n = sfep_pkg::SEC_PER_32K;
    end else if (q.op == sfep_pkg::OP_BLOCK64_WIPE) begin
      cmd_lo = {q.addr[20:16], 4'b0000};
      cmd_n = sfep_pkg::SEC_PER_64K;
    end
    cmd_prot = sfep_prot(cmd_lo, cmd_n, q.pss, q.bp, q.plock | q.dlock);
    walk_prot = sfep_prot({q.idx[4:0], 4'b0000}, sfep_pkg::SEC_PER_64K, q.pss, q.bp,
                          q.plock | q.dlock);

    d.mem_erase = 1'b0;
    d.mem_rd = 1'b0;
    d.mem_wr = 1'b0;
    d.rdata = 32'h0000_0000;

    // pins cross into sys_clk through two flops each
    d.cs_m = chip_select_n;
    d.cs_s = q.cs_m;
    d.cs_p = q.cs_s;
    d.sck_m = serial_clk;
    d.sck_s = q.sck_m;
    d.sck_p = q.sck_s;
    d.io_m = quad_io_lines;
    d.io_s = q.io_m;

    if (reg_we) begin
      if (reg_addr == sfep_pkg::REG_CTRL) begin
        d.pss = reg_wdata[sfep_pkg::CTRL_PSS_BIT];
        d.qe = reg_wdata[sfep_pkg::CTRL_QE_BIT];
        d.quad_command_mode = reg_wdata[sfep_pkg::CTRL_QPI_BIT];
        d.bp = reg_wdata[sfep_pkg::CTRL_BP_LSB +: 4];
      end else if (reg_addr == sfep_pkg::REG_LOCK_IDX) begin
        d.lock_idx = reg_wdata[8:0];
      end else if (reg_addr == sfep_pkg::REG_LOCK_DATA) begin
        d.plock[q.lock_idx] = reg_wdata[sfep_pkg::LOCK_PERSIST_BIT];
        d.dlock[q.lock_idx] = reg_wdata[sfep_pkg::LOCK_DYNAMIC_BIT];
      end
    end
    if (reg_re) begin
      if (reg_addr == sfep_pkg::REG_CTRL) begin
        d.rdata = {25'h0, q.bp, q.quad_command_mode, q.qe, q.pss};
      end else if (reg_addr == sfep_pkg::REG_STATUS) begin
        d.rdata = {29'h0, q.reject, q.latch, q.busy};
      end else if (reg_addr == sfep_pkg::REG_LOCK_IDX) begin
        d.rdata = {23'h0, q.lock_idx};
      end else if (reg_addr == sfep_pkg::REG_LOCK_DATA) begin
        d.rdata = {30'h0, q.dlock[q.lock_idx], q.plock[q.lock_idx]};
      end
    end

    if (q.st != sfep_pkg::ST_IDLE && q.timer != 32'h0000_0000) begin
      d.timer = q.timer - 32'd1;
    end

    // frames arriving while busy are not shifted in, but their chip select fall still clears the buffer's valid bits
    if (cs_fall) begin
      d.bitcnt = 4'h0;
      d.bytecnt = 3'd0;
      d.pval = '0;
    end else if (sck_rise && !q.cs_s && q.st == sfep_pkg::ST_IDLE) begin
      d.sh = nsh;
      d.bitcnt = nbit;
      if (nbit == 4'd8) begin
        d.bitcnt = 4'h0;
        if (q.bytecnt == 3'd0) begin
          d.op = nsh;
        end else if (q.bytecnt < 3'd4) begin
          d.addr = {q.addr[15:0], nsh};
          if (q.bytecnt == 3'd3) begin
            d.pofs = nsh;
          end
        end else begin
          // later bytes overwrite earlier ones at the same offset
          d.pbuf[q.pofs] = nsh;
          d.pval[q.pofs] = 1'b1;
          d.pofs = q.pofs + 8'd1;
        end
        if (q.bytecnt != 3'd5) begin
          d.bytecnt = q.bytecnt + 3'd1;
        end
      end
    end else if (cs_rise && q.st == sfep_pkg::ST_IDLE) begin
      d.bitcnt = 4'h0;
      d.bytecnt = 3'd0;
      case (q.op)
        sfep_pkg::OP_WRITE_UNLOCK: begin
          if (q.bytecnt == 3'd1 && bnd) begin
            d.latch = 1'b1;
          end
        end
        sfep_pkg::OP_FOUR_KIB_WIPE, sfep_pkg::OP_BLOCK32_WIPE,
        sfep_pkg::OP_BLOCK64_WIPE: begin
          if (q.bytecnt == 3'd4 && bnd && q.latch && !cmd_prot) begin
            d.busy = 1'b1;
            d.reject = 1'b0;
            d.mem_erase = 1'b1;
            d.mem_eaddr = {cmd_lo, 12'h000};
            d.st = sfep_pkg::ST_WAIT;
            if (q.op == sfep_pkg::OP_FOUR_KIB_WIPE) begin
              d.mem_len = sfep_pkg::LEN_4K;
              d.timer = SECTOR_WIPE_CYC;
            end else if (q.op == sfep_pkg::OP_BLOCK32_WIPE) begin
              d.mem_len = sfep_pkg::LEN_32K;
              d.timer = BLOCK32_WIPE_CYC;
            end else begin
              d.mem_len = sfep_pkg::LEN_64K;
              d.timer = BLOCK64_WIPE_CYC;
            end
          end else begin
            d.reject = 1'b1;
          end
        end
        sfep_pkg::OP_CHIP_WIPE: begin
          if (q.bytecnt == 3'd1 && bnd && q.latch && (q.pss || q.bp == 4'h0)) begin
            d.busy = 1'b1;
            d.reject = 1'b0;
            d.idx = 9'h000;
            d.timer = CHIP_WIPE_CYC;
            d.st = sfep_pkg::ST_WALK;
          end else begin
            d.reject = 1'b1;
          end
        end
        sfep_pkg::OP_PAGE_WRITE, sfep_pkg::OP_QUAD_PAGE_WRITE: begin
          if (q.bytecnt == 3'd5 && bnd && q.latch && !cmd_prot &&
              (q.op == sfep_pkg::OP_PAGE_WRITE || q.qe)) begin
            d.busy = 1'b1;
            d.reject = 1'b0;
            d.idx = 9'h000;
            d.timer = PAGE_WRITE_CYC;
            d.st = sfep_pkg::ST_PREAD;
          end else begin
            d.reject = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    case (q.st)
      sfep_pkg::ST_WALK: begin
        if (q.idx[5]) begin
          d.st = sfep_pkg::ST_WAIT;
        end else begin
          // one 64K erase per block; locked blocks are passed over
          if (!walk_prot) begin
            d.mem_erase = 1'b1;
            d.mem_len = sfep_pkg::LEN_64K;
            d.mem_eaddr = {q.idx[4:0], 16'h0000};
          end
          d.idx = q.idx + 9'd1;
        end
      end
      sfep_pkg::ST_PREAD: begin
        if (q.idx[8]) begin
          d.st = sfep_pkg::ST_WAIT;
        end else if (q.pval[q.idx[7:0]]) begin
          d.mem_rd = 1'b1;
          d.mem_addr = {q.addr[20:8], q.idx[7:0]};
          d.st = sfep_pkg::ST_PWRITE;
        end else begin
          d.idx = q.idx + 9'd1;
        end
      end
      sfep_pkg::ST_PWRITE: begin
        // read-modify-write keeps zeros at zero
        d.mem_wr = 1'b1;
        d.mem_wdata = mem_rdata & q.pbuf[q.idx[7:0]];
        d.idx = q.idx + 9'd1;
        d.st = sfep_pkg::ST_PREAD;
      end
      sfep_pkg::ST_WAIT: begin
        if (q.timer == 32'h0000_0000) begin
          d.busy = 1'b0;
          d.latch = 1'b0;
          d.st = sfep_pkg::ST_IDLE;
        end
      end
      default: begin
      end
    endcase

    if (srst) begin
      d = '0;
      d.cs_m = 1'b1;
      d.cs_s = 1'b1;
      d.cs_p = 1'b1;
      {d.bp, d.quad_command_mode, d.qe, d.pss} = sfep_pkg::CTRL_RESET;
      d.timer = sfep_pkg::TIMER_RESET;
      d.st = sfep_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    q <= d;
  end

  assign reg_rdata = q.rdata;
  assign busy_flag = q.busy;
  assign write_unlock_latch = q.latch;
  assign mem_erase = q.mem_erase;
  assign mem_erase_len = q.mem_len;
  assign mem_erase_addr = q.mem_eaddr;
  assign mem_rd = q.mem_rd;
  assign mem_wr = q.mem_wr;
  assign mem_addr = q.mem_addr;
  assign mem_wdata = q.mem_wdata;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  chk_start_needs_latch: assert property ($rose(q.busy) |-> $past(q.latch))
    else $error("cycle started without the unlock latch");
  chk_start_on_rise: assert property ($rose(q.busy) |-> $past(q.cs_s) && !$past(q.cs_p))
    else $error("cycle did not start on chip select rise");
  chk_start_on_bound: assert property ($rose(q.busy) |-> $past(q.bitcnt) == 4'h0)
    else $error("cycle started off a byte boundary");
  chk_busy_keeps_latch: assert property (q.busy |-> q.latch)
    else $error("latch dropped during the cycle");
  chk_done_clears: assert property ($fell(q.busy) |-> !q.latch && q.st == sfep_pkg::ST_IDLE)
    else $error("completion left latch set");
  chk_sector_align: assert property (q.mem_erase && q.mem_len == sfep_pkg::LEN_4K
                                     |-> q.mem_eaddr[11:0] == 12'h000 && q.busy)
    else $error("sector erase misaligned or outside a cycle");
  chk_only_clears: assert property (q.mem_wr |-> (q.mem_wdata & ~$past(mem_rdata)) == 8'h00)
    else $error("page write set a bit");
  chk_prog_in_page: assert property (q.mem_rd |=> q.mem_wr && q.mem_addr[20:8] == q.addr[20:8])
    else $error("page write left its page");
  chk_quad_needs_qe: assert property ($rose(q.busy) && q.op == sfep_pkg::OP_QUAD_PAGE_WRITE
                                      |-> q.qe)
    else $error("quad page write ran without quad enable");
  chk_chip_scheme0: assert property ($rose(q.busy) && q.op == sfep_pkg::OP_CHIP_WIPE && !q.pss
                                     |-> q.bp == 4'h0)
    else $error("chip wipe ran with protect bits set");
  chk_walk_skips: assert property (q.st == sfep_pkg::ST_WALK && !q.idx[5] && walk_prot
                                   |=> !q.mem_erase)
    else $error("chip wipe erased a locked block");

endmodule

// [verification/sfep_host_model.sv]
// host serial controller model that frames commands on the flash link
`timescale 1ns/1ps
module sfep_host_model (
  output logic chip_select_n,
  output logic serial_clk,
  output logic [3:0] quad_io_lines
);
  logic [7:0] frame_q [0:299];
  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    quad_io_lines = 4'h0;
  end
  // bytes from quad_from on go four bits a clock; extra adds stray clocks
  task automatic send(input int nbytes, input int quad_from, input int extra);
    int b;
    int k;
    int w;
    chip_select_n = 1'b0;
    for (b = 0; b < nbytes + 1; b++) begin
      w = (b >= quad_from) ? 4 : 1;
      for (k = 8 - w; k >= 0; k -= w) begin
        if (b == nbytes && k < 8 - extra) break;
        if (w == 4 && b < nbytes) quad_io_lines = frame_q[b][k +: 4];
        else quad_io_lines = {~quad_io_lines[3:1], frame_q[b % 300][k]};
        #62.5 serial_clk = 1'b1;
        #62.5 serial_clk = 1'b0;
      end
    end
    // rise right after the last latched bit unless stray bits were asked for
    #62.5 chip_select_n = 1'b1;
    // released lines must not look like held data
    quad_io_lines = ~quad_io_lines;
    #100;
  endtask
endmodule

// [verification/test_serial_flash_erase_program.sv]
// self-checking bench for the erase and page write sequencer
`timescale 1ns/1ps
module test_serial_flash_erase_program;
  logic sys_clk, srst, chip_select_n, serial_clk, reg_we, reg_re, busy_flag;
  logic write_unlock_latch, mem_erase, mem_rd, mem_wr;
  logic [3:0] quad_io_lines, reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [1:0] mem_erase_len;
  logic [20:0] mem_erase_addr, mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic [7:0] junk_q = 8'h00;
  logic [7:0] flash_q [int];
  logic [22:0] erase_q [$];
  logic [22:0] exp_erase [0:2];
  logic [7:0] ops [0:2];
  logic [23:0] adrs [0:2];
  int err_total = 0;
  int samples_checked = 0;
  int busy_cnt = 0;
  sfep_host_model host (.chip_select_n(chip_select_n), .serial_clk(serial_clk),
    .quad_io_lines(quad_io_lines));
  // one microsecond counts keep every timed cycle at 250 clocks
  sfep_sequencer #(.SECTOR_WIPE_TIME_US(1), .BLOCK32_WIPE_TIME_US(1),
    .BLOCK64_WIPE_TIME_US(1), .CHIP_WIPE_TIME_US(1)) dut (
    .sys_clk(sys_clk), .srst(srst), .chip_select_n(chip_select_n),
    .serial_clk(serial_clk), .quad_io_lines(quad_io_lines), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .busy_flag(busy_flag), .write_unlock_latch(write_unlock_latch),
    .mem_erase(mem_erase), .mem_erase_len(mem_erase_len),
    .mem_erase_addr(mem_erase_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // array answers within the read pulse's own cycle; unread data toggles so stale values fail
  function automatic logic [7:0] peek(input logic [20:0] a);
    return flash_q.exists(int'(a)) ? flash_q[int'(a)] : 8'hff;
  endfunction
  assign mem_rdata = mem_rd ? peek(mem_addr) : junk_q;
  always @(posedge sys_clk) begin
    junk_q <= ~junk_q;
    if (mem_wr) flash_q[int'(mem_addr)] = mem_wdata;
    if (mem_erase) erase_q.push_back({mem_erase_len, mem_erase_addr});
    if (busy_flag === 1'b1) busy_cnt++;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_we <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask
  task automatic setcmd(input logic [7:0] op, input logic [23:0] a);
    host.frame_q[0] = op;
    host.frame_q[1] = a[23:16];
    host.frame_q[2] = a[15:8];
    host.frame_q[3] = a[7:0];
    erase_q.delete();
  endtask
  task automatic unlock(input int qf);
    logic [7:0] keep;
    // the pending command's opcode must survive the unlock frame
    keep = host.frame_q[0];
    host.frame_q[0] = sfep_pkg::OP_WRITE_UNLOCK;
    host.send(1, qf, 0);
    host.frame_q[0] = keep;
    repeat (8) @(posedge sys_clk);
    chk("latch set", 32'h1, {31'h0, write_unlock_latch});
  endtask
  task automatic cmd(input int n, input int qf, input int extra, input logic ok);
    int t;
    busy_cnt = 0;
    host.send(n, qf, extra);
    repeat (8) @(posedge sys_clk);
    chk("busy start", {31'h0, ok}, {31'h0, busy_flag});
    if (ok) begin
      reg_rd(sfep_pkg::REG_STATUS, v);
      chk("status busy", 32'h3, {30'h0, v[1:0]});
    end
    for (t = 0; t < 20000 && busy_flag === 1'b1; t++) @(posedge sys_clk);
    chk("busy end", 32'h0, {31'h0, busy_flag});
    if (ok) chk("latch end", 32'h0, {31'h0, write_unlock_latch});
    reg_rd(sfep_pkg::REG_STATUS, v);
    chk("reject", {31'h0, ~ok}, {31'h0, v[sfep_pkg::STAT_REJECT_BIT]});
  endtask
  task automatic stop_test;
    if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    stop_test();
  end
  initial begin
    srst = 1'b1;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    ops = '{sfep_pkg::OP_FOUR_KIB_WIPE, sfep_pkg::OP_BLOCK32_WIPE, sfep_pkg::OP_BLOCK64_WIPE};
    adrs = '{24'he12345, 24'h01a123, 24'h01ffff};
    exp_erase = '{{sfep_pkg::LEN_4K, 21'h012000}, {sfep_pkg::LEN_32K, 21'h018000},
      {sfep_pkg::LEN_64K, 21'h010000}};
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    reg_rd(sfep_pkg::REG_STATUS, v);
    chk("status reset", 32'h0, v);
    reg_rd(4'h2, v);
    chk("unmapped", 32'h0, v);
    setcmd(ops[0], adrs[0]);
    cmd(4, 99, 0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      unlock(99);
      setcmd(ops[i], adrs[i]);
      cmd(4, 99, 0, 1'b1);
      chk("erase count", 32'h1, erase_q.size());
      chk("erase region", {9'h0, exp_erase[i]}, {9'h0, erase_q[0]});
      // busy spans the load cycle and every count down to zero
      chk("busy length", 32'(sfep_pkg::CLK_MHZ + 1), busy_cnt);
    end
    unlock(99);
    setcmd(ops[0], 24'h000000);
    cmd(4, 99, 1, 1'b0);
    reg_wr(sfep_pkg::REG_CTRL, 32'h4);
    unlock(0);
    setcmd(ops[0], 24'h005000);
    cmd(4, 0, 0, 1'b1);
    chk("quad opcode", {9'h0, sfep_pkg::LEN_4K, 21'h005000}, {9'h0, erase_q[0]});
    reg_wr(sfep_pkg::REG_CTRL, 32'h8);
    unlock(99);
    setcmd(ops[0], 24'h1f0000);
    cmd(4, 99, 0, 1'b0);
    setcmd(sfep_pkg::OP_PAGE_WRITE, 24'h1f0010);
    cmd(5, 99, 0, 1'b0);
    setcmd(sfep_pkg::OP_CHIP_WIPE, 24'h0);
    cmd(1, 99, 0, 1'b0);
    reg_wr(sfep_pkg::REG_CTRL, 32'h1);
    reg_wr(sfep_pkg::REG_LOCK_IDX, 32'h3);
    reg_wr(sfep_pkg::REG_LOCK_DATA, 32'h2);
    reg_rd(sfep_pkg::REG_LOCK_DATA, v);
    chk("lock read", 32'h2, v);
    setcmd(ops[0], 24'h003fff);
    cmd(4, 99, 0, 1'b0);
    unlock(99);
    setcmd(sfep_pkg::OP_CHIP_WIPE, 24'h0);
    cmd(1, 99, 0, 1'b1);
    chk("chip blocks", 32'd31, erase_q.size());
    chk("first block", {9'h0, sfep_pkg::LEN_64K, 21'h010000}, {9'h0, erase_q[0]});
    reg_wr(sfep_pkg::REG_LOCK_DATA, 32'h0);
    reg_wr(sfep_pkg::REG_CTRL, 32'h0);
    flash_q[32'h100] = 8'h3c;
    unlock(99);
    setcmd(sfep_pkg::OP_PAGE_WRITE, 24'h0001fe);
    host.frame_q[4] = 8'haa;
    host.frame_q[5] = 8'h55;
    host.frame_q[6] = 8'h0f;
    cmd(7, 99, 0, 1'b1);
    chk("page 1fe", 32'haa, {24'h0, flash_q[32'h1fe]});
    chk("page 1ff", 32'h55, {24'h0, flash_q[32'h1ff]});
    chk("page wrap", 32'h0c, {24'h0, flash_q[32'h100]});
    unlock(99);
    cmd(6, 99, 3, 1'b0);
    setcmd(sfep_pkg::OP_QUAD_PAGE_WRITE, 24'h000200);
    host.frame_q[4] = 8'h77;
    cmd(5, 1, 0, 1'b0);
    reg_wr(sfep_pkg::REG_CTRL, 32'h2);
    unlock(99);
    cmd(5, 1, 0, 1'b1);
    chk("quad byte", 32'h77, {24'h0, flash_q[32'h200]});
    unlock(99);
    setcmd(sfep_pkg::OP_QUAD_PAGE_WRITE, 24'h000300);
    for (int i = 0; i < 258; i++) host.frame_q[4 + i] = (i >= 256) ? 8'ha5 : 8'hc3;
    cmd(262, 1, 0, 1'b1);
    chk("last kept", 32'ha5, {24'h0, flash_q[32'h300]});
    chk("mid kept", 32'hc3, {24'h0, flash_q[32'h302]});
    stop_test();
  end
endmodule
